// ### design/tovr_pkg.sv
package tovr_pkg;

    // ------------------------------------------------------------------
    // Register map (AXI4-Lite byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_ACC_X = 8'h10;
    localparam logic [7:0] ADDR_ACC_Y = 8'h14;
    localparam logic [7:0] ADDR_CRC_REF = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_INV_POL_BIT = 0;
    localparam int CTRL_TILT_OFF_BIT = 1;
    localparam int IRQ_CHECK_DONE_BIT = 0;
    localparam int IRQ_CHECK_FAIL_BIT = 1;
    localparam int IRQ_OVR_FAULT_BIT = 2;
    localparam int IRQ_LOWG_FAULT_BIT = 3;
    localparam int IRQ_TIPOVER_BIT = 4;
    localparam int IRQ_WIDTH = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 5'h00;
    localparam logic [15:0] ACC_RESET = 16'h0400;
    localparam logic [15:0] CRC_REF_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Acceleration scale: signed 16 bit, 1 g = 1024 counts
    // ------------------------------------------------------------------
    localparam int ACC_WIDTH = 16;
    localparam logic [15:0] OVER_RANGE_LIMIT = 16'h0800;
    localparam logic [15:0] LOW_G_LIMIT = 16'h0180;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 100000000;
    localparam longint UPDATE_HZ = 3;
    localparam longint UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
    localparam longint FAULT_MS = 4000;
    localparam longint FAULT_TICKS = FAULT_MS * UPDATE_HZ / 1000;
    localparam longint CHECK_MS = 10;
    localparam longint CHECK_CYCLES = CHECK_MS * CLK_HZ / 1000;

    // ------------------------------------------------------------------
    // Threshold table: tan^2 of each angle, Q8 fixed point
    // ------------------------------------------------------------------
    function automatic logic [15:0] thr_tan2(input logic [2:0] sel);
        case (sel)
            3'h0: thr_tan2 = 16'h00B4;
            3'h1: thr_tan2 = 16'h0100;
            3'h2: thr_tan2 = 16'h016E;
            3'h3: thr_tan2 = 16'h020B;
            3'h4: thr_tan2 = 16'h0300;
            3'h5: thr_tan2 = 16'h04A1;
            3'h6: thr_tan2 = 16'h078C;
            default: thr_tan2 = 16'h00D8;
        endcase
    endfunction : thr_tan2

endpackage : tovr_pkg

// ### design/tovr_nvm_check.sv
module tovr_nvm_check #(
    parameter int unsigned WORDS = 16,
    parameter logic [15:0] CRC_INIT = 16'hFFFF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] expected,
    output logic done,
    output logic pass
);

    // ------------------------------------------------------------------
    // Factory image: fixed contents walked once after reset.
    // ------------------------------------------------------------------
    logic [15:0] image [0:WORDS-1];
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    logic [$clog2(WORDS+1)-1:0] idx_ff;
    logic [15:0] word;

    always_comb
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            image[i] = 16'(i * 16'h1357 + 16'h0A5A);
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 15; b >= 0; b--)
        begin
            r = (r[15] ^ d[b]) ? ((r << 1) ^ 16'h1021) : (r << 1);
        end
        return r;
    endfunction : crc_step

    assign word = image[idx_ff[$clog2(WORDS)-1:0]];
    assign nxt_crc = crc_step(crc_ff, word);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crc_ff <= CRC_INIT;
            idx_ff <= '0;
            done <= 1'b0;
            pass <= 1'b0;
        end
        else if (!done)
        begin
            if (idx_ff == WORDS[$clog2(WORDS+1)-1:0])
            begin
                done <= 1'b1;
                pass <= (crc_ff == expected);
            end
            else
            begin
                crc_ff <= nxt_crc;
                idx_ff <= idx_ff + 1'b1;
            end
        end
    end

endmodule : tovr_nvm_check

// ### design/tovr_fault_timer.sv
module tovr_fault_timer #(
    parameter int unsigned TICKS = 12
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic cond,
    output logic fault
);

    // Counts update ticks while the condition stands; any gap restarts it.
    // The tick phase at onset gives the spread of the delay.
    logic [$clog2(TICKS+1)-1:0] cnt_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            fault <= 1'b0;
        end
        else if (!cond)
        begin
            cnt_ff <= '0;
            fault <= 1'b0;
        end
        else if (tick)
        begin
            if (cnt_ff == TICKS[$clog2(TICKS+1)-1:0])
            begin
                fault <= 1'b1;
            end
            else
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

endmodule : tovr_fault_timer

// ### design/tovr_top.sv
// The AXI4-Lite slave port and the register addresses were decided locally.
module tovr_top #(
    parameter int unsigned UPDATE_CYCLES = 32'(tovr_pkg::UPDATE_CYCLES),
    parameter int unsigned FAULT_TICKS = 32'(tovr_pkg::FAULT_TICKS),
    parameter logic INVERTED_VARIANT = 1'b0
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic THRESHOLD_SEL_MSB,
    input wire logic THRESHOLD_SEL_MID,
    input wire logic THRESHOLD_SEL_LSB,
    output logic ALARM_O,
    output logic ALARM_OE,
    output logic IRQ,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CHECK = 4'h1,
        ST_RUN = 4'h2,
        ST_FAIL = 4'h4,
        ST_FAULT = 4'h8
    } tovr_state_e;

    tovr_state_e state_ff;
    logic [2:0] sel_meta_ff;
    logic [2:0] sel_ff;
    logic [1:0] ctrl_ff;
    logic [tovr_pkg::IRQ_WIDTH-1:0] irq_stat_ff;
    logic [tovr_pkg::IRQ_WIDTH-1:0] irq_mask_ff;
    logic [tovr_pkg::IRQ_WIDTH-1:0] events;
    logic signed [15:0] acc_x_ff;
    logic signed [15:0] acc_y_ff;
    logic [15:0] crc_ref_ff;
    logic [31:0] upd_cnt_ff;
    logic tick_ff;
    logic tip_ff;
    logic tip_prev_ff;
    logic check_done;
    logic check_pass;
    logic over_range;
    logic low_g;
    logic ovr_fault;
    logic lowg_fault;
    logic tilt_off;
    logic tip_now;
    logic [15:0] abs_x;
    logic [15:0] abs_y;
    logic [31:0] x_sq_q8;
    logic [31:0] y_sq_thr;
    logic [7:0] aw_addr_ff;
    logic aw_have_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_have_ff;
    logic wr_go;
    logic wr_hit;

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction : mag

    // ------------------------------------------------------------------
    // Strap synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel_meta_ff <= 3'h0;
            sel_ff <= 3'h0;
        end
        else
        begin
            sel_meta_ff <= {THRESHOLD_SEL_MSB, THRESHOLD_SEL_MID, THRESHOLD_SEL_LSB};
            sel_ff <= sel_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Power-up integrity check
    // ------------------------------------------------------------------
    tovr_nvm_check #(
        .WORDS(16),
        .CRC_INIT(16'hFFFF)
    ) u_check (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .expected(crc_ref_ff),
        .done(check_done),
        .pass(check_pass)
    );

    // ------------------------------------------------------------------
    // Update-rate divider
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            upd_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end
        else if (upd_cnt_ff == UPDATE_CYCLES - 1)
        begin
            upd_cnt_ff <= 32'h0;
            tick_ff <= 1'b1;
        end
        else
        begin
            upd_cnt_ff <= upd_cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Condition monitors and angle comparison
    // ------------------------------------------------------------------
    assign abs_x = mag(acc_x_ff);
    assign abs_y = mag(acc_y_ff);
    assign over_range = (abs_x > tovr_pkg::OVER_RANGE_LIMIT) || (abs_y > tovr_pkg::OVER_RANGE_LIMIT);
    assign low_g = (abs_x < tovr_pkg::LOW_G_LIMIT) && (abs_y < tovr_pkg::LOW_G_LIMIT);
    assign tilt_off = ctrl_ff[tovr_pkg::CTRL_TILT_OFF_BIT];
    // Angle from vertical exceeds threshold when x^2 > tan^2(thr) * y^2, or y is negative.
    assign x_sq_q8 = {16'h0000, abs_x} * {16'h0000, abs_x};
    assign y_sq_thr = 32'({16'h0000, tovr_pkg::thr_tan2(sel_ff)} * {16'h0000, abs_y}) >> 8;
    assign tip_now = acc_y_ff[15]
                     || (x_sq_q8 > 32'(64'(y_sq_thr) * 64'(abs_y)));

    tovr_fault_timer #(
        .TICKS(FAULT_TICKS)
    ) u_ovr_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_ff),
        .cond(over_range),
        .fault(ovr_fault)
    );

    tovr_fault_timer #(
        .TICKS(FAULT_TICKS)
    ) u_lowg_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_ff),
        .cond(low_g),
        .fault(lowg_fault)
    );

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tip_ff <= 1'b0;
            tip_prev_ff <= 1'b0;
        end
        else if (tick_ff && !low_g && !tilt_off)
        begin
            tip_ff <= tip_now;
            tip_prev_ff <= tip_ff;
        end
    end

    // ------------------------------------------------------------------
    // Output state machine
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_ff <= ST_CHECK;
        end
        else
        begin
            case (state_ff)
                ST_CHECK:
                begin
                    if (check_done)
                    begin
                        state_ff <= check_pass ? ST_RUN : ST_FAIL;
                    end
                end
                ST_RUN:
                begin
                    if (ovr_fault || lowg_fault)
                    begin
                        state_ff <= ST_FAULT;
                    end
                end
                ST_FAULT:
                begin
                    if (!ovr_fault && !lowg_fault)
                    begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_FAIL:
                begin
                    state_ff <= ST_FAIL;
                end
                default:
                begin
                    state_ff <= ST_FAIL;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ALARM_O <= 1'b0;
            ALARM_OE <= 1'b0;
        end
        else
        begin
            ALARM_O <= tip_ff ^ INVERTED_VARIANT ^ ctrl_ff[tovr_pkg::CTRL_INV_POL_BIT];
            ALARM_OE <= (state_ff == ST_RUN) && !ovr_fault && !lowg_fault;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign events = {
        tick_ff && (tip_ff != tip_prev_ff),
        lowg_fault && (state_ff == ST_RUN),
        ovr_fault && (state_ff == ST_RUN),
        check_done && !check_pass && (state_ff == ST_CHECK),
        check_done && check_pass && (state_ff == ST_CHECK)
    };

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_stat_ff <= '0;
            IRQ <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= (irq_stat_ff & ~((wr_hit && aw_addr_ff == tovr_pkg::ADDR_IRQ_STAT && w_strb_ff[0])
                ? w_data_ff[tovr_pkg::IRQ_WIDTH-1:0] : '0)) | events;
            IRQ <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign wr_go = aw_have_ff && w_have_ff && !S_AXI_BVALID;
    assign wr_hit = wr_go;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_have_ff && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_have_ff && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_have_ff <= 1'b1;
                w_data_ff <= S_AXI_WDATA;
                w_strb_ff <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go)
            begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_addr_ff <= tovr_pkg::ADDR_CRC_REF && aw_addr_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_ff <= tovr_pkg::CTRL_RESET;
            irq_mask_ff <= tovr_pkg::IRQ_MASK_RESET;
            acc_x_ff <= 16'h0000;
            acc_y_ff <= tovr_pkg::ACC_RESET;
            crc_ref_ff <= tovr_pkg::CRC_REF_RESET;
        end
        else if (wr_hit)
        begin
            if (aw_addr_ff == tovr_pkg::ADDR_CTRL && w_strb_ff[0])
            begin
                ctrl_ff <= w_data_ff[1:0];
            end
            else if (aw_addr_ff == tovr_pkg::ADDR_IRQ_MASK && w_strb_ff[0])
            begin
                irq_mask_ff <= w_data_ff[tovr_pkg::IRQ_WIDTH-1:0];
            end
            else if (aw_addr_ff == tovr_pkg::ADDR_ACC_X)
            begin
                if (w_strb_ff[0]) acc_x_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1]) acc_x_ff[15:8] <= w_data_ff[15:8];
            end
            else if (aw_addr_ff == tovr_pkg::ADDR_ACC_Y)
            begin
                if (w_strb_ff[0]) acc_y_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1]) acc_y_ff[15:8] <= w_data_ff[15:8];
            end
            else if (aw_addr_ff == tovr_pkg::ADDR_CRC_REF && state_ff == ST_CHECK)
            begin
                if (w_strb_ff[0]) crc_ref_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1]) crc_ref_ff[15:8] <= w_data_ff[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= 2'h0;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'h0;
                if (S_AXI_ARADDR == tovr_pkg::ADDR_CTRL)
                    S_AXI_RDATA <= {30'h0, ctrl_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_STATUS)
                    S_AXI_RDATA <= {20'h0, sel_ff, state_ff, lowg_fault, ovr_fault, low_g, over_range, tip_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_IRQ_STAT)
                    S_AXI_RDATA <= {27'h0, irq_stat_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_IRQ_MASK)
                    S_AXI_RDATA <= {27'h0, irq_mask_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_ACC_X)
                    S_AXI_RDATA <= {16'h0, acc_x_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_ACC_Y)
                    S_AXI_RDATA <= {16'h0, acc_y_ff};
                else if (S_AXI_ARADDR == tovr_pkg::ADDR_CRC_REF)
                    S_AXI_RDATA <= {16'h0, crc_ref_ff};
                else
                begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= 2'h2;
                end
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule : tovr_top

// ### tb/tovr_host_model.sv
module tovr_host_model (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic line,
    output logic driven
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff = 1'b0;
    always_ff @(posedge clk)
        if (pin_oe)
            last_ff <= pin_o;
    // A floating pin shows the inverse of its last level, so a stale value never looks driven.
    assign line = pin_oe ? pin_o : ~last_ff;
    assign driven = pin_oe;
endmodule : tovr_host_model

// ### tb/tovr_monitor.sv
module tovr_monitor (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic ALARM_OE,
    input wire logic IRQ,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR_MIN = 1;
    localparam int WR_MAX = 3;
    logic [5:0] cnt_ff;
    logic ever_ff;
    // --------------------------------------------------------------
    // Cycles since reset and whether the pin was ever driven.
    // --------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
        if (!RST_N)
            cnt_ff <= 6'h00;
        else if (cnt_ff != 6'h3F)
            cnt_ff <= cnt_ff + 6'h01;
    always_ff @(posedge SYS_CLK or negedge RST_N)
        if (!RST_N)
            ever_ff <= 1'b0;
        else if (ALARM_OE)
            ever_ff <= 1'b1;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    AST_FLOAT_AT_START: assert property (cnt_ff < 6'h0C |-> !ALARM_OE)
        else $error("alarm pin driven too early");
    AST_PASS_IN_TIME: assert property ($rose(ALARM_OE) && !ever_ff |-> cnt_ff < 6'h28)
        else $error("alarm pin driven late");
    AST_FAIL_STAYS_FLOAT: assert property (cnt_ff == 6'h3F && !ever_ff |-> !ALARM_OE)
        else $error("alarm pin driven after a failed check");
    AST_WRITE_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[WR_MIN:WR_MAX] S_AXI_BVALID)
        else $error("write response missing");
    AST_WRITE_CLOSE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response repeated");
    AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data missing");
    AST_READ_CLOSE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read data repeated");
    AST_RDATA_ERR: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
        else $error("refused read returned data");
    cover property ($rose(ALARM_OE));
    cover property ($fell(ALARM_OE));
    cover property ($rose(IRQ));
endmodule : tovr_monitor
bind tovr_top tovr_monitor u_mon (.SYS_CLK, .RST_N, .ALARM_OE, .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UPD = 10;
    localparam int FT = 3;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] rs;
    wire logic alarm_o, alarm_oe, irq, awready, wready, bvalid, arready, rvalid, line, driven;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int fail_count = 0, check_count = 0, seed = 32'h19f4, n;
    int exp_q[$];
    real thr[8] = '{40.0, 45.0, 50.0, 55.0, 60.0, 65.0, 70.0, 42.5};
    real a;
    always #5 sys_clk = ~sys_clk;
    tovr_top #(.UPDATE_CYCLES(UPD), .FAULT_TICKS(FT), .INVERTED_VARIANT(1'b0)) dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .THRESHOLD_SEL_MSB(sel[2]), .THRESHOLD_SEL_MID(sel[1]),
        .THRESHOLD_SEL_LSB(sel[0]), .ALARM_O(alarm_o), .ALARM_OE(alarm_oe), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    tovr_host_model host (.clk(sys_clk), .pin_o(alarm_o), .pin_oe(alarm_oe), .line(line), .driven(driven));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge sys_clk);
            if (awvalid && awready === 1'b1)
            begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1)
            begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
    endtask : wr
    task automatic rd_reg(input logic [7:0] ad);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rd_reg
    task automatic reset_dut();
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk({31'h0, driven}, 32'h0);
        rst_n <= 1'b1;
        @(posedge sys_clk);
    endtask : reset_dut
    task automatic wait_oe(input logic v, input int lim);
        while (driven !== v && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_oe
    function automatic logic [15:0] crc_ref();
        logic [15:0] c, w;
        c = 16'hFFFF;
        for (int i = 0; i < 16; i++)
        begin
            w = 16'(i * 16'h1357 + 16'h0A5A);
            for (int b = 15; b >= 0; b--)
                c = (c[15] ^ w[b]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_ref
    initial
    begin
        #500000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        reset_dut();
        repeat (60) @(posedge sys_clk);
        chk({31'h0, driven}, 32'h0);
        rd_reg(tovr_pkg::ADDR_IRQ_STAT);
        chk(rd & 32'h2, 32'h2);
        reset_dut();
        wr(tovr_pkg::ADDR_CRC_REF, {16'h0, crc_ref()});
        n = 0;
        wait_oe(1'b1, 40);
        chk({31'h0, driven}, 32'h1);
        for (int s = 0; s < 8; s++)
            for (int k = 0; k < 2; k++)
            begin
                sel <= 3'(s);
                a = (thr[s] + (k ? 1.0 : -1.0) * (3 + ($random(seed) & 3))) * 3.14159265 / 180.0;
                exp_q.push_back(k);
                wr(tovr_pkg::ADDR_ACC_X, 32'($rtoi(1024.0 * $sin(a))));
                wr(tovr_pkg::ADDR_ACC_Y, 32'($rtoi(1024.0 * $cos(a))));
                repeat (2 * UPD + 4) @(posedge sys_clk);
                chk({31'h0, line}, 32'(exp_q.pop_front()));
            end
        wr(tovr_pkg::ADDR_CTRL, 32'h1);
        repeat (2 * UPD + 4) @(posedge sys_clk);
        chk({31'h0, line}, 32'h0);
        wr(tovr_pkg::ADDR_CTRL, 32'h2);
        wr(tovr_pkg::ADDR_ACC_Y, 32'h800);
        repeat (2 * UPD + 4) @(posedge sys_clk);
        chk({31'h0, line}, 32'h1);
        wr(tovr_pkg::ADDR_CTRL, 32'h0);
        wr(tovr_pkg::ADDR_IRQ_MASK, 32'hC);
        wr(tovr_pkg::ADDR_ACC_X, 32'h170);
        wr(tovr_pkg::ADDR_ACC_Y, 32'h40);
        repeat (2 * UPD + 4) @(posedge sys_clk);
        chk({30'h0, driven, line}, 32'h2);
        n = 2 * UPD + 4;
        wait_oe(1'b0, (FT + 4) * UPD);
        chk(32'(n >= FT * UPD), 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, irq, driven}, 32'h2);
        wr(tovr_pkg::ADDR_ACC_X, 32'h0);
        wr(tovr_pkg::ADDR_ACC_Y, 32'h400);
        n = 0;
        wait_oe(1'b1, 4 * UPD);
        chk({31'h0, driven}, 32'h1);
        wr(tovr_pkg::ADDR_IRQ_STAT, 32'hC);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(tovr_pkg::ADDR_ACC_X, 32'hA00);
        n = 0;
        wait_oe(1'b0, (FT + 4) * UPD);
        chk(32'(n >= FT * UPD), 32'h1);
        repeat (3 * UPD) @(posedge sys_clk);
        chk({30'h0, irq, driven}, 32'h2);
        rd_reg(8'h40);
        chk({30'h0, rs}, 32'h2);
        end_sim();
    end
endmodule : tb
